// file: dv/lsm_far_side.sv
// lsm_far_side: system stack and data memory behind the unit
`timescale 1ns/1ps
`default_nettype none
module lsm_far_side (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // unit result
  input wire logic res_valid,
  input wire lsm_pkg::lsm_res_t res,
  // stack view
  output logic [15:0] stk_top,
  output logic [15:0] stk_below,
  output logic [7:0] stk_depth,
  // last store
  output logic [15:0] mem_last
);
  logic [15:0] stk [0:255];
  logic [15:0] mem [0:255];
  logic [7:0] sp;
  logic [7:0] wr_ix;
  assign mem_last = mem[wr_ix];
  logic [7:0] n_extra;
  logic [7:0] n_ret;
  assign n_extra = {7'h00, res.push_extra};
  assign n_ret = {7'h00, res.push_ret};
  assign stk_depth = sp;
  assign stk_top = stk[sp - 8'h01];
  assign stk_below = stk[sp - 8'h02];
  // extra word goes in before the return address
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sp <= 8'h00;
      wr_ix <= 8'h00;
    end else if (res_valid) begin
      if (res.push_extra) begin
        stk[sp] <= res.extra_data;
      end
      if (res.push_ret) begin
        stk[sp + n_extra] <= res.ret_addr;
      end
      if (res.mem_we) begin
        mem[res.mem_addr[8:1]] <= res.mem_data;
        wr_ix <= res.mem_addr[8:1];
      end
      sp <= sp + n_extra + n_ret;
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// testbench: directed checks of the loop, shift, move and branch unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk;
  logic reset;
  logic ce;
  logic req_valid;
  lsm_pkg::lsm_req_t req;
  lsm_pkg::lsm_req_t r;
  logic res_valid;
  lsm_pkg::lsm_res_t res;
  logic [15:0] stk_top;
  logic [15:0] stk_below;
  logic [7:0] stk_depth;
  logic [15:0] mem_last;
  int n_fail;
  int samples_checked;

  lsm_exec lsm_exec_i (.sys_clk(sys_clk), .reset(reset), .ce(ce), .req_valid(req_valid),
    .req(req), .res_valid(res_valid), .res(res));
  lsm_far_side lsm_far_side_i (.sys_clk(sys_clk), .reset(reset), .res_valid(res_valid),
    .res(res), .stk_top(stk_top), .stk_below(stk_below), .stk_depth(stk_depth),
    .mem_last(mem_last));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // request held high, taken at the next edge, result read half a cycle on
  task automatic go(input lsm_pkg::lsm_req_t q);
    req = q;
    req_valid = 1'b1;
    @(negedge sys_clk);
    chk(res_valid, 1'b1, "valid");
  endtask

  task automatic idle(input string name);
    req_valid = 1'b0;
    @(negedge sys_clk);
    chk(res_valid, 1'b0, "idle valid");
    chk(res.reg_data, 16'h0000, "idle res");
    $display("done %s", name);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_loop();
    logic [15:0] step [4] = '{16'h0007, 16'h0006, 16'h0009, 16'h000a};
    r = '0;
    r.op = lsm_pkg::compare_dec_one;
    r.form = lsm_pkg::FM_IMM4;
    r.dst_val = 16'h0005;
    r.src_val = 16'h0005;
    go(r);
    chk(res.reg_data, 16'h0004, "dec one");
    chk(res.length, lsm_pkg::LEN_SHORT, "short length");
    ce = 1'b0;
    req_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(res.reg_data, 16'h0004, "held while ce low");
    ce = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r.op = lsm_pkg::lsm_op_t'(i);
      r.form = i[0] ? lsm_pkg::FM_DIRECT : lsm_pkg::FM_IMM16;
      r.dst_val = 16'h0008;
      r.src_val = 16'h0008;
      go(r);
      chk(res.reg_data, step[i], "loop step");
      chk(res.flags[lsm_pkg::FLAG_Z], 1'b1, "flags before step");
      chk(res.length, lsm_pkg::LEN_LONG, "long length");
    end
    idle("loop");
  endtask

  task automatic t_shift();
    logic [15:0] want [5] = '{16'h4210, 16'h0842, 16'h4218, 16'h1842, 16'hf842};
    r = '0;
    r.dst_val = 16'h8421;
    r.src_val = 16'hfff4;
    for (int i = 0; i < 5; i++) begin
      r.op = lsm_pkg::lsm_op_t'(i + 5);
      r.form = i[0] ? lsm_pkg::FM_IMM4 : lsm_pkg::FM_REG;
      go(r);
      chk(res.reg_data, want[i], "shift");
      chk(res.length, lsm_pkg::LEN_SHORT, "shift length");
    end
    r.op = lsm_pkg::logical_shift_left;
    r.dst_val = 16'h8001;
    r.src_val = 16'h0001;
    go(r);
    chk(res.reg_data, 16'h0002, "shift by one");
    chk(res.flags, 4'h4, "shift carry out");
    r.op = lsm_pkg::normalize_count;
    r.form = lsm_pkg::FM_REG;
    r.src_val = 16'h0010;
    go(r);
    chk(res.reg_data, 16'h000b, "normalize");
    idle("shift");
  endtask

  task automatic t_move();
    r = '0;
    r.op = lsm_pkg::word_transfer;
    r.form = lsm_pkg::FM_POST_INC;
    r.ptr_val = 16'h0100;
    r.src_val = 16'h1234;
    go(r);
    chk(res.ptr_data, 16'h0102, "word post inc");
    r.op = lsm_pkg::byte_transfer;
    go(r);
    chk(res.ptr_data, 16'h0101, "byte post inc");
    r.to_mem = 1'b1;
    go(r);
    chk(res.ptr_data, 16'h0101, "byte dst post inc");
    r.form = lsm_pkg::FM_PRE_DEC;
    go(r);
    chk(res.mem_addr, 16'h00ff, "byte pre dec");
    r.op = lsm_pkg::word_transfer;
    go(r);
    chk(res.mem_addr, 16'h00fe, "word pre dec");
    chk(res.ptr_data, 16'h00fe, "word pre dec ptr");
    chk(res.mem_we, 1'b1, "word store");
    chk(res.mem_data, 16'h1234, "word store data");
    r.form = lsm_pkg::FM_BASE_OFS;
    r.imm16 = 16'h0020;
    go(r);
    chk(res.mem_addr, 16'h0120, "base plus offset");
    chk(res.length, lsm_pkg::LEN_LONG, "offset length");
    r.op = lsm_pkg::byte_transfer;
    go(r);
    chk(res.mem_addr, 16'h0120, "byte base plus offset");
    chk(res.mem_byte, 1'b1, "byte offset store");
    r.op = lsm_pkg::byte_sign_extend_transfer;
    r.form = lsm_pkg::FM_REG;
    r.to_mem = 1'b0;
    r.src_val = 16'h0085;
    go(r);
    chk(res.reg_data, 16'hff85, "sign extend");
    r.op = lsm_pkg::byte_zero_extend_transfer;
    r.src_val = 16'hff85;
    go(r);
    chk(res.reg_data, 16'h0085, "zero extend");
    chk(mem_last, 16'h0034, "last byte stored");
    idle("move");
  endtask

  task automatic t_jump();
    r = '0;
    r.op = lsm_pkg::cond_relative_jump;
    r.cond = lsm_pkg::CC_Z;
    r.ip_next = 16'h0200;
    r.imm16 = 16'h00fe;
    r.flags = 4'h1;
    go(r);
    chk(res.branch, 1'b1, "jump taken");
    chk(res.target, 16'h01fc, "relative target");
    r.op = lsm_pkg::cond_absolute_jump;
    r.cond = lsm_pkg::CC_NZ;
    go(r);
    chk(res.branch, 1'b0, "jump not taken");
    r.op = lsm_pkg::jump_bit_set_then_clear;
    r.bit_val = 1'b1;
    go(r);
    chk(res.branch, 1'b1, "test clear taken");
    chk({res.bit_we, res.bit_data}, 2'b10, "bit cleared");
    chk(res.length, lsm_pkg::LEN_LONG, "bit jump length");
    r.op = lsm_pkg::jump_if_bit_clear;
    go(r);
    chk(res.branch, 1'b0, "bit set, no jump");
    r.op = lsm_pkg::jump_bit_clear_then_set;
    r.bit_val = 1'b0;
    go(r);
    chk({res.branch, res.bit_we, res.bit_data}, 3'b111, "bit set");
    r.op = lsm_pkg::jump_if_bit_set;
    go(r);
    chk(res.branch, 1'b0, "bit clear, no jump");
    r.op = lsm_pkg::cond_indirect_jump;
    r.cond = lsm_pkg::CC_UC;
    r.src_val = 16'h0abc;
    go(r);
    chk(res.branch, 1'b1, "indirect jump taken");
    chk(res.target, 16'h0abc, "indirect target");
    r.op = lsm_pkg::segment_jump;
    r.seg_num = 8'h02;
    r.imm16 = 16'h0040;
    go(r);
    chk({res.seg_we, res.seg}, 9'h102, "jump segment");
    chk(res.target, 16'h0040, "segment jump target");
    idle("jump");
  endtask

  task automatic t_call();
    r = '0;
    r.op = lsm_pkg::cond_absolute_subroutine;
    r.cond = lsm_pkg::CC_NZ;
    r.flags = 4'h1;
    r.ip_next = 16'h0300;
    r.imm16 = 16'h4000;
    go(r);
    chk(res.push_ret, 1'b0, "call skipped");
    r.op = lsm_pkg::relative_subroutine;
    go(r);
    chk(res.push_ret, 1'b1, "relative call");
    r.op = lsm_pkg::cond_indirect_subroutine;
    r.cond = lsm_pkg::CC_Z;
    r.src_val = 16'h5000;
    go(r);
    chk(res.push_ret, 1'b1, "indirect call");
    chk(res.target, 16'h5000, "indirect call target");
    r.op = lsm_pkg::push_then_subroutine;
    r.src_val = 16'h1234;
    go(r);
    chk(res.target, 16'h4000, "push call target");
    r.op = lsm_pkg::segment_subroutine;
    r.seg_num = 8'h03;
    go(r);
    chk(stk_top, 16'h0300, "return on top");
    chk(stk_below, 16'h1234, "register below");
    chk({res.seg_we, res.seg}, 9'h103, "new segment");
    chk(res.target, 16'h4000, "segment target");
    r.op = lsm_pkg::software_trap;
    r.trap_num = 7'h05;
    go(r);
    chk(res.trap, 1'b1, "trap");
    chk(res.target, 16'h0014, "trap vector");
    chk(res.trap_num, 7'h05, "trap number");
    idle("call");
    chk(stk_depth, 8'h07, "stack depth");
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    reset = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req = '0;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    chk(res_valid, 1'b0, "after reset");
    t_loop();
    t_shift();
    t_move();
    t_jump();
    t_call();
    test_done();
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire

// file: logic/lsm_exec.sv
// lsm_exec: execute stage for loop, shift, move and branch instructions
// Operation
// - compare, then decrement register by 1 or 2
// - compare, then increment register by 1 or 2
// - data4 forms 2 bytes, data16/direct/base-offset 4 bytes
// - normalize count written to destination
// - logical shifts by register or data4 count
// - rotates by register or data4 count
// - arithmetic right shift replicates sign bit
// - post-increment pointer by 2 word, 1 byte
// - word pre-decrement pointer by 2 first
// - byte pre-decrement 1, destination post-increment 1
// - address is pointer plus 16-bit constant
// - sign-extend byte into word
// - zero-extend byte into word
// - conditional jumps only when condition true
// - bit-test jumps on set or clear bit
// - test-and-clear jumps and clears set bit
// - test-and-set jumps and sets clear bit
// - absolute/indirect subroutine calls conditional, relative and segment always
// - segment transfers load segment and address
// - push register, then absolute call
// - trap enters routine by 7-bit number
`timescale 1ns/1ps
`default_nettype none
module lsm_exec (
  // clock, clock enable and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // decoded instruction in
  input wire logic req_valid,
  input wire lsm_pkg::lsm_req_t req,
  // execution result out
  output var logic res_valid,
  output var lsm_pkg::lsm_res_t res
);
  // ****************************************
  // functions
  // ****************************************
  function automatic logic cond_true(input logic [3:0] cc, input logic [3:0] f);
    logic n = f[lsm_pkg::FLAG_N];
    logic c = f[lsm_pkg::FLAG_C];
    logic v = f[lsm_pkg::FLAG_V];
    logic z = f[lsm_pkg::FLAG_Z];
    case (cc)
      lsm_pkg::CC_UC: return 1'b1;
      lsm_pkg::CC_Z: return z;
      lsm_pkg::CC_NZ: return !z;
      lsm_pkg::CC_V: return v;
      lsm_pkg::CC_NV: return !v;
      lsm_pkg::CC_N: return n;
      lsm_pkg::CC_NN: return !n;
      lsm_pkg::CC_ULT: return c;
      lsm_pkg::CC_UGE: return !c;
      lsm_pkg::CC_UGT: return !c && !z;
      lsm_pkg::CC_ULE: return c || z;
      lsm_pkg::CC_SLT: return n ^ v;
      lsm_pkg::CC_SGE: return !(n ^ v);
      lsm_pkg::CC_SGT: return !(n ^ v) && !z;
      lsm_pkg::CC_SLE: return (n ^ v) || z;
      default: return 1'b0;
    endcase
  endfunction

  // zero word gives zero count
  function automatic logic [15:0] lead_zero(input logic [15:0] w);
    logic [15:0] n;
    n = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (w[i]) begin
        n = 16'(15 - i);
      end
    end
    return n;
  endfunction

  function automatic logic [3:0] nz_flags(input logic [15:0] d, input logic c);
    return {d[15], c, 1'b0, d == 16'h0000};
  endfunction

  // ****************************************
  // decode and datapath
  // ****************************************
  wire lsm_pkg::lsm_op_t op = req.op;
  wire lsm_pkg::lsm_form_t fm = req.form;
  lsm_pkg::lsm_res_t next_res;
  wire logic [15:0] a = req.dst_val;
  wire logic [15:0] b = req.src_val;
  wire logic [3:0] cnt = req.src_val[3:0];

  wire logic long_form = (fm == lsm_pkg::FM_IMM16) || (fm == lsm_pkg::FM_DIRECT)
    || (fm == lsm_pkg::FM_BASE_OFS);
  wire logic long_branch = (op == lsm_pkg::cond_absolute_jump)
    || (op == lsm_pkg::segment_jump) || (op == lsm_pkg::cond_absolute_subroutine)
    || (op == lsm_pkg::segment_subroutine) || (op == lsm_pkg::push_then_subroutine)
    || (op >= lsm_pkg::jump_if_bit_set && op <= lsm_pkg::jump_bit_clear_then_set);
  wire logic [2:0] length = (long_form || long_branch) ? lsm_pkg::LEN_LONG
    : lsm_pkg::LEN_SHORT;

  // compare on the value before the step
  wire logic [16:0] diff = {1'b0, a} - {1'b0, b};
  wire logic cmp_v = (a[15] ^ b[15]) & (a[15] ^ diff[15]);
  wire logic [3:0] cmp_flags = {diff[15], diff[16], cmp_v,
    diff[15:0] == 16'h0000};
  wire logic loop_two = (op == lsm_pkg::compare_dec_two)
    || (op == lsm_pkg::compare_inc_two);
  wire logic loop_dec = (op == lsm_pkg::compare_dec_one) || (op == lsm_pkg::compare_dec_two);
  wire logic [15:0] loop_step = loop_two ? lsm_pkg::STEP_TWO : lsm_pkg::STEP_ONE;
  wire logic [15:0] loop_val = loop_dec ? a - loop_step : a + loop_step;

  // shifts and rotates
  wire logic [16:0] left_ext = {1'b0, a} << cnt;
  wire logic [16:0] right_ext = {a, 1'b0} >> cnt;
  wire logic [16:0] sra_ext = 17'($signed({a, 1'b0}) >>> cnt);
  wire logic [4:0] rot_back = lsm_pkg::WORD_BITS - {1'b0, cnt};
  wire logic [15:0] rotl_val = (a << cnt) | (a >> rot_back);
  wire logic [15:0] rotr_val = (a >> cnt) | (a << rot_back);
  // carry flag in bit 16, result below
  wire logic [16:0] sh_out = (op == lsm_pkg::logical_shift_left) ? left_ext
    : (op == lsm_pkg::logical_shift_right) ? {right_ext[0], right_ext[16:1]}
    : (op == lsm_pkg::arith_right_shift) ? {sra_ext[0], sra_ext[16:1]}
    : (op == lsm_pkg::rotate_leftward) ? {rotl_val[0], rotl_val}
    : {rotr_val[15], rotr_val};

  // moves: address, pointer update, data
  wire logic is_byte = (op == lsm_pkg::byte_transfer);
  wire logic [15:0] step = is_byte ? lsm_pkg::STEP_ONE : lsm_pkg::STEP_TWO;
  wire logic [15:0] ptr_inc = req.ptr_val + step;
  wire logic [15:0] ptr_dec = req.ptr_val - step;
  wire logic [15:0] ofs_addr = req.ptr_val + req.imm16;
  wire logic [15:0] mv_addr = (fm == lsm_pkg::FM_PRE_DEC) ? ptr_dec
    : (fm == lsm_pkg::FM_BASE_OFS) ? ofs_addr
    : (fm == lsm_pkg::FM_DIRECT) ? req.imm16 : req.ptr_val;
  wire logic mv_reg_form = (fm == lsm_pkg::FM_REG) || (fm == lsm_pkg::FM_IMM4)
    || (fm == lsm_pkg::FM_IMM16);
  wire logic [15:0] mv_data = (op == lsm_pkg::byte_sign_extend_transfer)
    ? {{8{b[7]}}, b[7:0]}
    : (op == lsm_pkg::word_transfer) ? b : {8'h00, b[7:0]};

  // branches
  wire logic cc_ok = cond_true(req.cond, req.flags);
  wire logic [15:0] rel_target = req.ip_next
    + {{7{req.imm16[7]}}, req.imm16[7:0], 1'b0};
  wire logic [15:0] trap_target = 16'(req.trap_num) << lsm_pkg::TRAP_VEC_SHIFT;
  wire logic [15:0] jmp_target = (op == lsm_pkg::cond_indirect_jump) ? b
    : (op == lsm_pkg::cond_relative_jump) ? rel_target : req.imm16;

  // ****************************************
  // result assembly
  // ****************************************
  always_comb begin
    next_res = lsm_pkg::RES_RESET;
    next_res.length = length;
    next_res.ret_addr = req.ip_next;
    case (op)
      lsm_pkg::compare_dec_one, lsm_pkg::compare_dec_two,
      lsm_pkg::compare_inc_one, lsm_pkg::compare_inc_two: begin
        next_res.reg_we = 1'b1;
        next_res.reg_data = loop_val;
        next_res.flags_we = 1'b1;
        next_res.flags = cmp_flags;
      end
      lsm_pkg::normalize_count: begin
        next_res.reg_we = 1'b1;
        next_res.reg_data = lead_zero(b);
        next_res.flags_we = 1'b1;
        next_res.flags = nz_flags(next_res.reg_data, 1'b0);
      end
      lsm_pkg::logical_shift_left, lsm_pkg::logical_shift_right, lsm_pkg::arith_right_shift,
      lsm_pkg::rotate_leftward, lsm_pkg::rotate_rightward: begin
        next_res.reg_we = 1'b1;
        next_res.reg_data = sh_out[15:0];
        next_res.flags_we = 1'b1;
        next_res.flags = nz_flags(sh_out[15:0], sh_out[16]);
      end
      lsm_pkg::word_transfer, lsm_pkg::byte_transfer,
      lsm_pkg::byte_sign_extend_transfer, lsm_pkg::byte_zero_extend_transfer: begin
        next_res.reg_we = mv_reg_form || !req.to_mem;
        next_res.reg_byte = is_byte;
        next_res.reg_data = mv_data;
        next_res.mem_acc = !mv_reg_form;
        next_res.mem_we = !mv_reg_form && req.to_mem;
        next_res.mem_byte = is_byte;
        next_res.mem_addr = mv_addr;
        next_res.mem_data = mv_data;
        next_res.ptr_we = (fm == lsm_pkg::FM_POST_INC) || (fm == lsm_pkg::FM_PRE_DEC);
        next_res.ptr_data = (fm == lsm_pkg::FM_PRE_DEC) ? ptr_dec : ptr_inc;
        next_res.flags_we = 1'b1;
        next_res.flags = nz_flags(mv_data, req.flags[lsm_pkg::FLAG_C]);
      end
      lsm_pkg::cond_absolute_jump, lsm_pkg::cond_indirect_jump, lsm_pkg::cond_relative_jump: begin
        next_res.branch = cc_ok;
        next_res.target = jmp_target;
      end
      lsm_pkg::segment_jump: begin
        next_res.branch = 1'b1;
        next_res.target = req.imm16;
        next_res.seg_we = 1'b1;
        next_res.seg = req.seg_num;
      end
      lsm_pkg::jump_if_bit_set, lsm_pkg::jump_bit_set_then_clear: begin
        next_res.branch = req.bit_val;
        next_res.target = rel_target;
        next_res.bit_we = req.bit_val && (op == lsm_pkg::jump_bit_set_then_clear);
        next_res.bit_data = 1'b0;
      end
      lsm_pkg::jump_if_bit_clear, lsm_pkg::jump_bit_clear_then_set: begin
        next_res.branch = !req.bit_val;
        next_res.target = rel_target;
        next_res.bit_we = !req.bit_val && (op == lsm_pkg::jump_bit_clear_then_set);
        next_res.bit_data = 1'b1;
      end
      lsm_pkg::cond_absolute_subroutine, lsm_pkg::cond_indirect_subroutine: begin
        next_res.branch = cc_ok;
        next_res.push_ret = cc_ok;
        next_res.target = (op == lsm_pkg::cond_indirect_subroutine) ? b : req.imm16;
      end
      lsm_pkg::relative_subroutine: begin
        next_res.branch = 1'b1;
        next_res.push_ret = 1'b1;
        next_res.target = rel_target;
      end
      lsm_pkg::segment_subroutine: begin
        next_res.branch = 1'b1;
        next_res.push_extra = 1'b1;
        next_res.extra_data = {8'h00, req.cur_seg};
        next_res.push_ret = 1'b1;
        next_res.target = req.imm16;
        next_res.seg_we = 1'b1;
        next_res.seg = req.seg_num;
      end
      lsm_pkg::push_then_subroutine: begin
        next_res.branch = 1'b1;
        next_res.push_extra = 1'b1;
        next_res.extra_data = b;
        next_res.push_ret = 1'b1;
        next_res.target = req.imm16;
      end
      lsm_pkg::software_trap: begin
        next_res.trap = 1'b1;
        next_res.trap_num = req.trap_num;
        next_res.branch = 1'b1;
        next_res.push_ret = 1'b1;
        next_res.target = trap_target;
      end
      default: begin
        next_res.length = lsm_pkg::LEN_SHORT;
      end
    endcase
  end

  // ****************************************
  // result register
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      res <= lsm_pkg::RES_RESET;
      res_valid <= 1'b0;
    end else if (ce) begin
      res <= req_valid ? next_res : lsm_pkg::RES_RESET;
      res_valid <= req_valid;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_issue(lsm_pkg::lsm_op_t o);
    ce && req_valid && req.op == o;
  endsequence

  property p_dec_two;
    s_issue(lsm_pkg::compare_dec_two) |=> res_valid && res.reg_we
      && res.reg_data == $past(req.dst_val) - 16'h0002;
  endproperty
  a_dec_two: assert property (p_dec_two) else $error("dec by two wrong");

  property p_inc_one;
    s_issue(lsm_pkg::compare_inc_one) |=> res.reg_data == $past(req.dst_val) + 16'h0001
      && res.flags[lsm_pkg::FLAG_Z] == ($past(req.dst_val) == $past(req.src_val));
  endproperty
  a_inc_one: assert property (p_inc_one) else $error("inc by one wrong");

  property p_len;
    ce && req_valid && req.form == lsm_pkg::FM_IMM16 |=> res.length == 3'h4;
  endproperty
  a_len: assert property (p_len) else $error("length not four");

  property p_sign_shift;
    s_issue(lsm_pkg::arith_right_shift) |=> res.reg_data[15] == $past(req.dst_val[15]);
  endproperty
  a_sign_shift: assert property (p_sign_shift) else $error("sign not kept");

  property p_post_inc;
    ce && req_valid && req.op == lsm_pkg::word_transfer && req.form == lsm_pkg::FM_POST_INC
      |=> res.ptr_we && res.ptr_data == $past(req.ptr_val) + 16'h0002;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post inc wrong");

  property p_pre_dec;
    ce && req_valid && req.op == lsm_pkg::word_transfer && req.form == lsm_pkg::FM_PRE_DEC
      && req.to_mem |=> res.mem_we && res.mem_addr == $past(req.ptr_val) - 16'h0002
      && res.ptr_data == res.mem_addr;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre dec wrong");

  property p_base;
    ce && req_valid && req.form == lsm_pkg::FM_BASE_OFS && req.op == lsm_pkg::byte_transfer
      |=> res.mem_addr == $past(req.ptr_val) + $past(req.imm16);
  endproperty
  a_base: assert property (p_base) else $error("base address wrong");

  property p_sext;
    s_issue(lsm_pkg::byte_sign_extend_transfer)
      |=> res.reg_data[15:8] == {8{$past(req.src_val[7])}};
  endproperty
  a_sext: assert property (p_sext) else $error("sign extend wrong");

  property p_tclr;
    s_issue(lsm_pkg::jump_bit_set_then_clear)
      |=> res.branch == res.bit_we && res.bit_we == $past(req.bit_val) && !res.bit_data;
  endproperty
  a_tclr: assert property (p_tclr) else $error("test clear wrong");

  property p_rcall;
    s_issue(lsm_pkg::relative_subroutine) ##1 ce |-> res.branch && res.push_ret;
  endproperty
  a_rcall: assert property (p_rcall) else $error("relative call skipped");
endmodule
`default_nettype wire

// file: logic/lsm_pkg.sv
// lsm_pkg: types and constants of the loop/shift/move/branch unit
package lsm_pkg;
  // ****************************************
  // steps, lengths, flag positions
  // ****************************************
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [2:0] LEN_SHORT = 3'h2;
  localparam logic [2:0] LEN_LONG = 3'h4;
  localparam int FLAG_N = 3;
  localparam int FLAG_C = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 0;
  localparam int TRAP_VEC_SHIFT = 2;
  localparam logic [4:0] WORD_BITS = 5'h10;

  // ****************************************
  // condition codes
  // ****************************************
  localparam logic [3:0] CC_UC = 4'h0;
  localparam logic [3:0] CC_Z = 4'h1;
  localparam logic [3:0] CC_NZ = 4'h2;
  localparam logic [3:0] CC_V = 4'h3;
  localparam logic [3:0] CC_NV = 4'h4;
  localparam logic [3:0] CC_N = 4'h5;
  localparam logic [3:0] CC_NN = 4'h6;
  localparam logic [3:0] CC_ULT = 4'h7;
  localparam logic [3:0] CC_UGE = 4'h8;
  localparam logic [3:0] CC_UGT = 4'h9;
  localparam logic [3:0] CC_ULE = 4'ha;
  localparam logic [3:0] CC_SLT = 4'hb;
  localparam logic [3:0] CC_SGE = 4'hc;
  localparam logic [3:0] CC_SGT = 4'hd;
  localparam logic [3:0] CC_SLE = 4'he;

  // ****************************************
  // operations, operand forms, carriers
  // ****************************************
  typedef enum logic [4:0] {
    compare_dec_one, compare_dec_two, compare_inc_one, compare_inc_two,
    normalize_count, logical_shift_left, logical_shift_right,
    rotate_leftward, rotate_rightward, arith_right_shift,
    word_transfer, byte_transfer, byte_sign_extend_transfer,
    byte_zero_extend_transfer, cond_absolute_jump, cond_indirect_jump,
    cond_relative_jump, segment_jump, jump_if_bit_set,
    jump_bit_set_then_clear, jump_if_bit_clear, jump_bit_clear_then_set,
    cond_absolute_subroutine, cond_indirect_subroutine,
    relative_subroutine, segment_subroutine, push_then_subroutine,
    software_trap
  } lsm_op_t;

  typedef enum logic [2:0] {
    FM_REG, FM_IMM4, FM_IMM16, FM_DIRECT, FM_IND, FM_POST_INC,
    FM_PRE_DEC, FM_BASE_OFS
  } lsm_form_t;

  typedef struct packed {
    lsm_op_t op;
    lsm_form_t form;
    logic to_mem;
    logic [3:0] cond;
    logic [15:0] dst_val;
    logic [15:0] src_val;
    logic [15:0] ptr_val;
    logic [15:0] imm16;
    logic [6:0] trap_num;
    logic [7:0] seg_num;
    logic [7:0] cur_seg;
    logic bit_val;
    logic [3:0] flags;
    logic [15:0] ip_next;
  } lsm_req_t;

  typedef struct packed {
    logic [2:0] length;
    logic reg_we;
    logic reg_byte;
    logic [15:0] reg_data;
    logic ptr_we;
    logic [15:0] ptr_data;
    logic mem_acc;
    logic mem_we;
    logic mem_byte;
    logic [15:0] mem_addr;
    logic [15:0] mem_data;
    logic flags_we;
    logic [3:0] flags;
    logic branch;
    logic [15:0] target;
    logic seg_we;
    logic [7:0] seg;
    logic push_extra;
    logic [15:0] extra_data;
    logic push_ret;
    logic [15:0] ret_addr;
    logic bit_we;
    logic bit_data;
    logic trap;
    logic [6:0] trap_num;
  } lsm_res_t;

  localparam lsm_res_t RES_RESET = '0;
endpackage
